// [verilog/tci_timer.sv]
// Three-channel 16-bit interval timer with pacer cascade and byte register port
// What this block does
// - three 16-bit down-counters with clock, gate, output
// - counter 1 and counter 0 (timer) clocked from internal 10 MHz source
// - counter 0 timer or event counter, gated
// - counters 1,2 cascade; counter-2 rise triggers conversion
// - counts move as low and high bytes
// - control word fields: select, access, mode, decimal
// - select codes 0..2 pick counter; 3 read-back
// - access: latch, low, high, low then high
// - mode field decode, top bit ignored for 2/3
// - binary or BCD down counting
// - read-back latches count and/or status of selected
// - status byte: output, null count, programming
// - mode 0: low until terminal count, then high
// - mode 0: first byte stops, second restarts
// - mode 1: retriggerable one-shot from gate rise
// - mode 1: new count waits for next trigger
// - mode 2: one-clock low pulse every count
// - mode 2: low gate forces high, rise restarts
// - mode 3: even count, decrement by two, toggle
// - mode 3: odd count steps one and three
// - mode 4: strobe once at terminal count
// - mode 5: gate rise starts count, strobe
`timescale 1ns/100ps
`default_nettype none
module tci_timer (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  // Register port
  input  wire logic [4:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Counter 0 pins
  input  wire logic       CNT0_EXT_SEL,
  input  wire logic       EVENT_CLOCK_IN,
  input  wire logic       FIRST_COUNTER_GATE_IN,
  output logic            CNT0_OUT,
  // Pacer pins
  input  wire logic       PACER_GATE_IN,
  output logic            PACER_OUT,
  output logic            AD_TRIGGER
);

  tci_pkg::tci_state_type r;
  tci_pkg::tci_state_type nxt;

  // Down count by one to three, binary or BCD, wrapping at zero
  function automatic logic [15:0] sub_cnt(input logic [15:0] v, input logic [1:0] n, input logic bcd);
    logic [4:0]  d;
    logic [1:0]  b;
    logic [15:0] res;
    res = 16'h0000;
    b = n;
    if (!bcd)
    begin
      return v - {14'h0000, n};
    end
    for (int k = 0; k < 4; k++)
    begin
      d = {1'b0, v[4*k +: 4]} - {3'h0, b};
      if (d[4])
      begin
        d = d + 5'h0a;
        b = 2'h1;
      end
      else
      begin
        b = 2'h0;
      end
      res[4*k +: 4] = d[3:0];
    end
    return res;
  endfunction : sub_cnt

  // Top mode bit is a don't-care for the rate modes
  function automatic tci_pkg::tci_mode_type eff_mode(input logic [2:0] m);
    return tci_pkg::tci_mode_type'(m[1] ? {1'b0, m[1:0]} : m);
  endfunction : eff_mode

  always_comb
  begin
    tci_pkg::tci_state_type s;
    tci_pkg::tci_cnt_type   x;
    tci_pkg::tci_mode_type  m;
    logic [2:0]  g;
    logic [1:0]  sel;
    logic [1:0]  acc;
    logic [1:0]  step;
    logic [15:0] v;
    logic        tk;
    logic        trg;
    logic        hi;
    logic        done;
    s = r;
    x = r.c[0];
    m = tci_pkg::MODE0;
    sel = WDATA[tci_pkg::SEL_POS +: 2];
    acc = 2'h0;
    step = 2'h2;
    v = 16'h0000;
    tk = 1'b0;
    trg = 1'b0;
    hi = 1'b0;
    done = 1'b0;
    g = {PACER_GATE_IN, PACER_GATE_IN, FIRST_COUNTER_GATE_IN};
    s.rdata = tci_pkg::RD_IDLE;
    s.ev_q = EVENT_CLOCK_IN;
    // 10 MHz enable from the 50 MHz clock
    s.div = (r.div == tci_pkg::DIV_LAST) ? '0 : r.div + 1'b1;
    if (WR && ADDR == tci_pkg::ADR_CTRL)
    begin
      if (sel == tci_pkg::SEL_RB)
      begin
        for (int i = 0; i < 3; i++)
        begin
          if (WDATA[tci_pkg::RB_SEL_POS + i])
          begin
            if (!WDATA[tci_pkg::RB_CNT_POS] && !s.c[i].lat_v)
            begin
              s.c[i].lat = s.c[i].cnt;
              s.c[i].lat_v = 1'b1;
            end
            if (!WDATA[tci_pkg::RB_STA_POS] && !s.c[i].sts_v)
            begin
              s.c[i].sts = {s.c[i].out, s.c[i].nul, s.c[i].ctrl};
              s.c[i].sts_v = 1'b1;
            end
          end
        end
      end
      else if (WDATA[tci_pkg::ACC_POS +: 2] == tci_pkg::ACC_LATCH)
      begin
        if (!s.c[sel].lat_v)
        begin
          s.c[sel].lat = s.c[sel].cnt;
          s.c[sel].lat_v = 1'b1;
        end
      end
      else
      begin
        s.c[sel].ctrl = WDATA[5:0];
        s.c[sel].out = eff_mode(WDATA[tci_pkg::MODE_POS +: 3]) != tci_pkg::MODE0;
        s.c[sel].run = 1'b0;
        s.c[sel].ld = 1'b0;
        s.c[sel].nul = 1'b1;
        s.c[sel].wr_hi = 1'b0;
        s.c[sel].rd_hi = 1'b0;
        s.c[sel].lat_v = 1'b0;
        s.c[sel].sts_v = 1'b0;
      end
    end
    for (int i = 0; i < 3; i++)
    begin
      x = s.c[i];
      acc = x.ctrl[tci_pkg::ACC_POS +: 2];
      m = eff_mode(x.ctrl[tci_pkg::MODE_POS +: 3]);
      if (WR && ADDR == tci_pkg::ADR_CNT0 + 5'(2 * i))
      begin
        done = 1'b1;
        case (acc)
          tci_pkg::ACC_LO:
          begin
            x.rld = {8'h00, WDATA};
          end
          tci_pkg::ACC_HI:
          begin
            x.rld = {WDATA, 8'h00};
          end
          tci_pkg::ACC_BOTH:
          begin
            if (!x.wr_hi)
            begin
              x.rld[7:0] = WDATA;
              done = 1'b0;
              if (m == tci_pkg::MODE0)
              begin
                x.run = 1'b0;
              end
            end
            else
            begin
              x.rld[15:8] = WDATA;
            end
            x.wr_hi = ~x.wr_hi;
          end
          default:
          begin
            done = 1'b0;
          end
        endcase
        if (done)
        begin
          x.ld = 1'b1;
          x.nul = 1'b1;
          if (m == tci_pkg::MODE0)
          begin
            x.out = 1'b0;
          end
        end
      end
      if (RD && ADDR == tci_pkg::ADR_CNT0 + 5'(2 * i))
      begin
        if (x.sts_v)
        begin
          s.rdata = x.sts;
          x.sts_v = 1'b0;
        end
        else
        begin
          // Reading never touches the counting element
          v = x.lat_v ? x.lat : x.cnt;
          hi = (acc == tci_pkg::ACC_HI) || (acc == tci_pkg::ACC_BOTH && x.rd_hi);
          s.rdata = hi ? v[15:8] : v[7:0];
          if (acc != tci_pkg::ACC_BOTH || x.rd_hi)
          begin
            x.lat_v = 1'b0;
          end
          if (acc == tci_pkg::ACC_BOTH)
          begin
            x.rd_hi = ~x.rd_hi;
          end
        end
      end
      // Counter 0 takes internal or event clock; counter 2 runs on counter 1
      case (i)
        0: tk = CNT0_EXT_SEL ? (EVENT_CLOCK_IN & ~r.ev_q) : (r.div == tci_pkg::DIV_LAST);
        1: tk = r.div == tci_pkg::DIV_LAST;
        default: tk = s.c[1].out & ~r.c[1].out;
      endcase
      if (tk)
      begin
        trg = g[i] & ~x.gate_q;
        x.gate_q = g[i];
        case (m)
          tci_pkg::MODE0, tci_pkg::MODE4:
          begin
            if (m == tci_pkg::MODE4)
            begin
              x.out = 1'b1;
            end
            if (x.ld)
            begin
              x.cnt = x.rld;
              x.ld = 1'b0;
              x.nul = 1'b0;
              x.run = 1'b1;
            end
            else if (x.run && g[i])
            begin
              x.cnt = sub_cnt(x.cnt, 2'h1, x.ctrl[tci_pkg::BCD_POS]);
              if (x.cnt == 16'h0000)
              begin
                x.out = m == tci_pkg::MODE0;
                x.run = m == tci_pkg::MODE0;
              end
            end
          end
          tci_pkg::MODE1, tci_pkg::MODE5:
          begin
            if (m == tci_pkg::MODE5)
            begin
              x.out = 1'b1;
            end
            if (trg && (x.ld || !x.nul))
            begin
              x.cnt = x.rld;
              x.ld = 1'b0;
              x.nul = 1'b0;
              x.run = 1'b1;
              x.out = m == tci_pkg::MODE5;
            end
            else if (x.run)
            begin
              x.cnt = sub_cnt(x.cnt, 2'h1, x.ctrl[tci_pkg::BCD_POS]);
              if (x.cnt == 16'h0000)
              begin
                x.out = m == tci_pkg::MODE1;
                x.run = 1'b0;
              end
            end
          end
          tci_pkg::MODE2, tci_pkg::MODE3:
          begin
            step = (x.first && x.cnt[0]) ? (x.out ? 2'h1 : 2'h3) : 2'h2;
            if (!g[i])
            begin
              x.out = 1'b1;
            end
            else if ((trg && (x.ld || !x.nul)) || (x.ld && !x.run))
            begin
              x.cnt = x.rld;
              x.ld = 1'b0;
              x.nul = 1'b0;
              x.run = 1'b1;
              x.first = 1'b1;
              x.out = 1'b1;
            end
            else if (x.run && m == tci_pkg::MODE2)
            begin
              if (x.cnt == 16'h0001)
              begin
                x.cnt = x.rld;
                x.ld = 1'b0;
                x.nul = 1'b0;
                x.out = 1'b1;
              end
              else
              begin
                x.cnt = sub_cnt(x.cnt, 2'h1, x.ctrl[tci_pkg::BCD_POS]);
                x.out = x.cnt != 16'h0001;
              end
            end
            else if (x.run)
            begin
              x.first = 1'b0;
              x.cnt = sub_cnt(x.cnt, step, x.ctrl[tci_pkg::BCD_POS]);
              if (x.cnt == 16'h0000)
              begin
                x.out = ~x.out;
                x.cnt = x.rld;
                x.ld = 1'b0;
                x.nul = 1'b0;
                x.first = 1'b1;
              end
            end
          end
          default:
          begin
            x.run = 1'b0;
          end
        endcase
      end
      s.c[i] = x;
    end
    s.trig = s.c[2].out & ~r.c[2].out;
    nxt = s;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      r <= tci_pkg::ST_RST;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign RDATA      = r.rdata;
  assign CNT0_OUT   = r.c[0].out;
  assign PACER_OUT  = r.c[2].out;
  assign AD_TRIGGER = r.trig;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_cw0(logic [2:0] md);
    WR && ADDR == tci_pkg::ADR_CTRL && WDATA[7:4] == 4'h3 && WDATA[3:1] == md;
  endsequence
  sequence s_rb_sta0;
    WR && ADDR == tci_pkg::ADR_CTRL && WDATA[7:6] == 2'h3 && !WDATA[4] && WDATA[1] && !r.c[0].sts_v;
  endsequence
  sequence s_rd0;
    !WR && RD && ADDR == tci_pkg::ADR_CNT0;
  endsequence

  a_div_period: assert property (r.div == tci_pkg::DIV_LAST |=> (r.div != tci_pkg::DIV_LAST)[*4] ##1 r.div == tci_pkg::DIV_LAST)
    else $error("counter clock enable not every five cycles");
  a_pacer_trig: assert property (AD_TRIGGER == $rose(PACER_OUT))
    else $error("conversion trigger not tied to pacer rising edge");
  a_mode0_low: assert property (s_cw0(3'b000) |=> !CNT0_OUT)
    else $error("mode 0 output not low after mode set");
  a_mode1_idle: assert property (s_cw0(3'b001) |=> CNT0_OUT)
    else $error("mode 1 output not high after mode set");
  a_status_read: assert property (s_rb_sta0 ##1 (!RD && !WR) ##1 s_rd0
    |=> RDATA[5:0] == r.c[0].ctrl && RDATA[7] == $past(CNT0_OUT, 3))
    else $error("status byte does not match programming");
  a_ctrl_unmapped: assert property (RD && ADDR == tci_pkg::ADR_CTRL |=> RDATA == tci_pkg::RD_IDLE)
    else $error("control word read not zero");
  a_mode0_stop: assert property (WR && ADDR == tci_pkg::ADR_CNT0 && r.c[0].ctrl[5:1] == 5'b11000 && !r.c[0].wr_hi
    |=> !r.c[0].run && r.c[0].wr_hi)
    else $error("first byte did not stop mode 0 counting");
  a_mode4_strobe: assert property ($fell(CNT0_OUT) && r.c[0].ctrl[3:1] == 3'b100 && !CNT0_EXT_SEL && !WR
    |-> ##[1:5] CNT0_OUT)
    else $error("mode 4 strobe longer than one counter clock");
  a_latch_hold: assert property (r.c[0].lat_v && !WR && !RD |=> r.c[0].lat == $past(r.c[0].lat))
    else $error("latched count changed without access");

endmodule : tci_timer
`default_nettype wire

// [pkg/tci_pkg.sv]
// Constants and types shared by the three-channel interval timer
package tci_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned CNT_CLK_HZ = 10_000_000;
  localparam int unsigned DIV_CYC    = CLK_HZ / CNT_CLK_HZ;
  localparam int unsigned DIV_W      = $clog2(DIV_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYC - 1);
  localparam logic [4:0] ADR_CNT0 = 5'h18;
  localparam logic [4:0] ADR_CNT1 = 5'h1a;
  localparam logic [4:0] ADR_CNT2 = 5'h1c;
  localparam logic [4:0] ADR_CTRL = 5'h1e;
  localparam int unsigned SEL_POS    = 6;
  localparam int unsigned ACC_POS    = 4;
  localparam int unsigned MODE_POS   = 1;
  localparam int unsigned BCD_POS    = 0;
  localparam int unsigned RB_CNT_POS = 5;
  localparam int unsigned RB_STA_POS = 4;
  localparam int unsigned RB_SEL_POS = 1;
  localparam logic [1:0] SEL_RB = 2'h3;
  localparam logic [7:0] RD_IDLE = 8'h00;
  typedef enum logic [1:0] {
    ACC_LATCH = 2'b00,
    ACC_LO    = 2'b01,
    ACC_HI    = 2'b10,
    ACC_BOTH  = 2'b11
  } tci_acc_type;
  typedef enum logic [2:0] {
    MODE0 = 3'b000,
    MODE1 = 3'b001,
    MODE2 = 3'b010,
    MODE3 = 3'b011,
    MODE4 = 3'b100,
    MODE5 = 3'b101
  } tci_mode_type;
  typedef struct packed {
    logic [5:0]  ctrl;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] lat;
    logic [7:0]  sts;
    logic        lat_v;
    logic        sts_v;
    logic        rd_hi;
    logic        wr_hi;
    logic        ld;
    logic        run;
    logic        out;
    logic        nul;
    logic        gate_q;
    logic        first;
  } tci_cnt_type;
  typedef struct packed {
    tci_cnt_type [2:0] c;
    logic [DIV_W-1:0]  div;
    logic              ev_q;
    logic              trig;
    logic [7:0]        rdata;
  } tci_state_type;
  localparam tci_state_type ST_RST = '0;
endpackage : tci_pkg

// [verif/tci_evt_src.sv]
// External event source feeding the counter-0 event clock pin
`timescale 1ns/100ps
`default_nettype none
module tci_evt_src (
  // Clock
  input  wire logic       clk,
  // Burst request
  input  wire logic       start,
  input  wire logic [7:0] n_ev,
  // Event pin
  output logic            ev,
  output logic            busy
);
  logic [7:0] left_r;
  logic [1:0] ph_r;
  initial
  begin
    ev     = 1'b0;
    busy   = 1'b0;
    left_r = 8'h00;
    ph_r   = 2'h0;
  end
  // Two cycles high, two low per event; idle low between bursts
  always @(posedge clk)
  begin
    if (start && !busy)
    begin
      left_r <= n_ev;
      busy   <= (n_ev != 8'h00);
      ph_r   <= 2'h0;
    end
    else if (busy)
    begin
      ph_r <= ph_r + 2'h1;
      ev   <= (ph_r < 2'h2);
      if (ph_r == 2'h3)
      begin
        left_r <= left_r - 8'h01;
        busy   <= (left_r != 8'h01);
      end
    end
    else
      ev <= 1'b0;
  end
endmodule : tci_evt_src
`default_nettype wire

// [verif/tci_timer_tb.sv]
// Self-checking testbench for the three-channel interval timer
`timescale 1ns/100ps
`default_nettype none
module tci_timer_tb;
  logic       clk;
  logic       rst;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ext_sel;
  logic       ev;
  logic       gate0;
  logic       c0_out;
  logic       pgate;
  logic       p_out;
  logic       ad_trig;
  logic       ev_go;
  logic [7:0] ev_n;
  logic       ev_busy;
  logic       p_q;
  int         err_count;
  int         n_tests;
  int         cyc;
  int         n_lo;
  int         gap;

  tci_timer dut (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CNT0_EXT_SEL(ext_sel), .EVENT_CLOCK_IN(ev), .FIRST_COUNTER_GATE_IN(gate0),
    .CNT0_OUT(c0_out), .PACER_GATE_IN(pgate), .PACER_OUT(p_out), .AD_TRIGGER(ad_trig)
  );
  tci_evt_src u_src (.clk(clk), .start(ev_go), .n_ev(ev_n), .ev(ev), .busy(ev_busy));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic events(input logic [7:0] n);
    @(posedge clk);
    ev_go <= 1'b1;
    ev_n  <= n;
    @(posedge clk);
    ev_go <= 1'b0;
    #1;
    while (ev_busy)
    begin
      @(posedge clk);
      #1;
    end
    idle(4);
  endtask : events

  // Trigger pulse must sit on the first cycle of a high pacer output
  always @(posedge clk)
  begin
    cyc++;
    n_lo += !c0_out;
    if (!rst)
      chk("ad_trigger", {7'h00, ad_trig}, {7'h00, p_out && !p_q});
    p_q <= p_out;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    n_lo = 0;
    p_q = 1'b0;
    rst = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ext_sel = 1'b0;
    gate0 = 1'b1;
    pgate = 1'b1;
    ev_go = 1'b0;
    ev_n = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(2);
    chk("c0_out rst", {7'h00, c0_out}, 8'h00);
    rd_reg("unmapped", 5'h05, 8'h00);
    rd_reg("ctrl read", tci_pkg::ADR_CTRL, 8'h00);
    // Mode 0, both bytes, count 5 on counter 0
    wr_reg(tci_pkg::ADR_CTRL, 8'h30);
    idle(2);
    chk("m0 out set", {7'h00, c0_out}, 8'h00);
    wr_reg(tci_pkg::ADR_CNT0, 8'h05);
    wr_reg(tci_pkg::ADR_CNT0, 8'h00);
    idle(20);
    chk("m0 out run", {7'h00, c0_out}, 8'h00);
    idle(40);
    chk("m0 out tc", {7'h00, c0_out}, 8'h01);
    // Status read-back of counter 0
    wr_reg(tci_pkg::ADR_CTRL, 8'he2);
    rd_reg("status c0", tci_pkg::ADR_CNT0, 8'hb0);
    // Count keeps running past terminal count and wraps
    wr_reg(tci_pkg::ADR_CTRL, 8'h00);
    rd_reg("latch lo", tci_pkg::ADR_CNT0, 8'hf9);
    rd_reg("latch hi", tci_pkg::ADR_CNT0, 8'hff);
    // Mode 4, low byte only, count 3: one strobe of one tick
    wr_reg(tci_pkg::ADR_CTRL, 8'h18);
    idle(2);
    chk("m4 out set", {7'h00, c0_out}, 8'h01);
    n_lo = 0;
    wr_reg(tci_pkg::ADR_CNT0, 8'h03);
    idle(150);
    chk("m4 strobe", 8'(n_lo), 8'(tci_pkg::DIV_CYC));
    // Mode 1, both bytes, count 3: gate rise fires one low pulse
    wr_reg(tci_pkg::ADR_CTRL, 8'h32);
    idle(2);
    chk("m1 idle", {7'h00, c0_out}, 8'h01);
    wr_reg(tci_pkg::ADR_CNT0, 8'h03);
    wr_reg(tci_pkg::ADR_CNT0, 8'h00);
    gate0 = 1'b0;
    idle(10);
    gate0 = 1'b1;
    idle(8);
    chk("m1 pulse", {7'h00, c0_out}, 8'h00);
    idle(20);
    chk("m1 end", {7'h00, c0_out}, 8'h01);
    // Mode 3, low byte, odd count 3: low one tick of three
    wr_reg(tci_pkg::ADR_CTRL, 8'h16);
    wr_reg(tci_pkg::ADR_CNT0, 8'h03);
    idle(10);
    n_lo = 0;
    idle(150);
    chk("m3 low", 8'(n_lo), 8'(10 * tci_pkg::DIV_CYC));
    // Event counting, mode 0, count 3
    ext_sel = 1'b1;
    wr_reg(tci_pkg::ADR_CTRL, 8'h10);
    wr_reg(tci_pkg::ADR_CNT0, 8'h03);
    events(8'h03);
    chk("evt before tc", {7'h00, c0_out}, 8'h00);
    events(8'h01);
    chk("evt at tc", {7'h00, c0_out}, 8'h01);
    // Decimal count: 10 minus one is 09
    wr_reg(tci_pkg::ADR_CTRL, 8'h11);
    wr_reg(tci_pkg::ADR_CNT0, 8'h10);
    events(8'h02);
    wr_reg(tci_pkg::ADR_CTRL, 8'h00);
    rd_reg("bcd count", tci_pkg::ADR_CNT0, 8'h09);
    // Pacer cascade: mode 2 with count 2 on counters 1 and 2
    wr_reg(tci_pkg::ADR_CTRL, 8'h74);
    wr_reg(tci_pkg::ADR_CNT1, 8'h02);
    wr_reg(tci_pkg::ADR_CNT1, 8'h00);
    wr_reg(tci_pkg::ADR_CTRL, 8'hb4);
    wr_reg(tci_pkg::ADR_CNT2, 8'h02);
    wr_reg(tci_pkg::ADR_CNT2, 8'h00);
    gap = 0;
    while (!ad_trig && gap < 200)
    begin
      @(posedge clk);
      #1;
      gap++;
    end
    gap = 0;
    do
    begin
      @(posedge clk);
      #1;
      gap++;
    end
    while (!ad_trig && gap < 200);
    chk("pacer period", 8'(gap), 8'(4 * tci_pkg::DIV_CYC));
    // Low gate holds the pacer output high
    pgate = 1'b0;
    idle(30);
    chk("gate low", {7'h00, p_out}, 8'h01);
    complete_run();
  end
endmodule : tci_timer_tb
`default_nettype wire
